/* File: rtl/pbg_gate_top.sv */
// protection blocking gate: wishbone registers, pin synchronisers,
// processing-cycle divider, global gate, neutral release timer, stages
// assumes a classic wishbone master on mclk and measurement logic on mclk
//
// Notes on behaviour
// - global disable stops every stage
// - each stage has its own enable
// - permanent trip block suppresses stage trip only
// - global blocked while permitted assigned signal high
// - stage blocked by permitted input a or b
// - permitted external trip block suppresses trip
// - any assignment list signal may block
// - fundamental elements blocked outside nominal frequency
// - rms elements ignore frequency range
// - supervision-only stage: no alarm, no trip
// - direction mode none, forward or reverse
// - stage delay adds after direction release
// - direction released after threshold plus delay
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pbg_regs.svh"

module pbg_gate_top
  import pbg_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // pins from outside the clock domain
  input  wire logic [7:0]  assignPin,
  input  wire logic        freqInRangePin,
  // measurement logic on mclk
  input  wire logic [15:0] neutralVoltage,
  input  wire logic        dirFwd,
  input  wire logic        dirRev,
  input  wire logic [3:0]  stagePickup,
  // gated results
  output logic             protActive,
  output logic             dirReleased,
  output logic [3:0]       stageActive,
  output logic [3:0]       stageAlarm,
  output logic [3:0]       stageTrip,
  output logic             genAlarm,
  output logic             genTrip
);

  localparam int NSTG = `PBG_NSTG;

  // byte-lane merge, used by every writable register
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r;
  endfunction : wmerge

  // register file state
  logic [8:0]     ctrl_r, ctrl_nxt;
  logic [15:0]    nvMin_r, nvMin_nxt;
  logic [15:0]    nvDly_r, nvDly_nxt;
  pbg_stage_cfg_t cfg_r [NSTG];
  pbg_stage_cfg_t cfg_nxt [NSTG];
  logic [15:0]    dly_r [NSTG];
  logic [15:0]    dly_nxt [NSTG];
  logic           ack_nxt;
  logic [31:0]    dat_nxt;

  // bus decode
  logic           hit, wr, inStg;
  logic [7:0]     stgOfs;
  logic [1:0]     stgIdx;
  logic [31:0]    stsWord;

  // synchronisers and filtered levels
  logic [8:0]     sync1_r, sync2_r, sync3_r;
  logic [8:0]     filt_r, filt_nxt;

  // divider
  logic [4:0]     divCnt_r, divCnt_nxt;
  logic           tick_r, tick_nxt;

  // global gate, release timer and general outputs
  logic           protAct_nxt;
  pbg_tmr_state_t rl_r, rl_nxt;
  logic [15:0]    rlCnt_r, rlCnt_nxt;
  logic           rel_nxt, nvAbove;
  logic           genAlarm_nxt, genTrip_nxt;

  // stage wiring
  logic [15:0]    assignVec;
  pbg_stage_in_t  sin [NSTG];
  pbg_stage_out_t sout [NSTG];
  logic [3:0]     operVec;
  pbg_dir_t       dirBus;

  assign stgOfs = wb_adr_i - `PBG_OFS_STG0;
  assign stgIdx = stgOfs[4:3];
  assign inStg  = (wb_adr_i >= `PBG_OFS_STG0) && (wb_adr_i < `PBG_OFS_STGEND);
  assign hit    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o; // lands on the edge the master samples ack
  assign stsWord = {11'h000, filt_r[8], stageTrip, operVec, stageAlarm, stageActive,
                    2'h0, dirReleased, protActive};

  // register writes and read mux; ack one cycle after the request,
  // dropped the cycle after; a write lands with ack, not a cycle early
  always_comb begin
    ctrl_nxt  = ctrl_r;
    nvMin_nxt = nvMin_r;
    nvDly_nxt = nvDly_r;
    cfg_nxt   = cfg_r;
    dly_nxt   = dly_r;
    ack_nxt   = hit;
    dat_nxt   = 32'h0000_0000; // unmapped reads answer zero
    if (wr) begin
      unique case (wb_adr_i)
        `PBG_OFS_CTRL:  ctrl_nxt  = 9'(wmerge({23'h000000, ctrl_r}, wb_dat_i, wb_sel_i));
        `PBG_OFS_NVMIN: nvMin_nxt = 16'(wmerge({16'h0000, nvMin_r}, wb_dat_i, wb_sel_i));
        `PBG_OFS_NVDLY: nvDly_nxt = 16'(wmerge({16'h0000, nvDly_r}, wb_dat_i, wb_sel_i));
        default: begin
          if (inStg && !stgOfs[2]) begin
            cfg_nxt[stgIdx] = pbg_stage_cfg_t'(23'(wmerge({9'h000, cfg_r[stgIdx]}, wb_dat_i, wb_sel_i)));
          end else if (inStg) begin
            dly_nxt[stgIdx] = 16'(wmerge({16'h0000, dly_r[stgIdx]}, wb_dat_i, wb_sel_i));
          end
        end
      endcase
    end
    if (hit && !wb_we_i) begin
      unique case (wb_adr_i)
        `PBG_OFS_CTRL:   dat_nxt = {23'h000000, ctrl_r};
        `PBG_OFS_STATUS: dat_nxt = stsWord;
        `PBG_OFS_NVMIN:  dat_nxt = {16'h0000, nvMin_r};
        `PBG_OFS_NVDLY:  dat_nxt = {16'h0000, nvDly_r};
        default: begin
          if (inStg && !stgOfs[2]) dat_nxt = {9'h000, cfg_r[stgIdx]};
          else if (inStg) dat_nxt = {16'h0000, dly_r[stgIdx]};
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r   <= `PBG_CTRL_RST;
      nvMin_r  <= `PBG_CNT_RST;
      nvDly_r  <= `PBG_CNT_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      for (int i = 0; i < NSTG; i++) begin
        cfg_r[i] <= pbg_stage_cfg_t'(`PBG_CFG_RST);
        dly_r[i] <= `PBG_CNT_RST;
      end
    end else begin
      ctrl_r   <= ctrl_nxt;
      nvMin_r  <= nvMin_nxt;
      nvDly_r  <= nvDly_nxt;
      wb_ack_o <= ack_nxt;
      wb_dat_o <= dat_nxt;
      cfg_r    <= cfg_nxt;
      dly_r    <= dly_nxt;
    end
  end

  // pin synchronisers; a level counts once stages two and three agree,
  // which costs a cycle but rejects a single-cycle glitch
  always_comb begin
    filt_nxt = filt_r;
    for (int i = 0; i < 9; i++) begin
      if (sync2_r[i] == sync3_r[i]) filt_nxt[i] = sync3_r[i];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= 9'h000;
      sync2_r <= 9'h000;
      sync3_r <= 9'h000;
      filt_r  <= 9'h000;
    end else begin
      sync1_r <= {freqInRangePin, assignPin};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r  <= filt_nxt;
    end
  end

  // processing-cycle divider
  always_comb begin
    tick_nxt   = (divCnt_r == 5'(`PBG_PROC_CYC - 1));
    divCnt_nxt = tick_nxt ? 5'h00 : divCnt_r + 5'h01;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      divCnt_r <= 5'h00;
      tick_r   <= 1'b0;
    end else begin
      divCnt_r <= divCnt_nxt;
      tick_r   <= tick_nxt;
    end
  end

  // assignment list: synced pins plus internal stage states
  assign assignVec = {stageTrip, stageAlarm, filt_r[7:0]};

  // global gate and neutral release timer, both stepped per processing cycle
  always_comb begin
    protAct_nxt = protActive;
    rl_nxt      = rl_r;
    rlCnt_nxt   = rlCnt_r;
    nvAbove     = neutralVoltage > nvMin_r;
    if (tick_r) begin
      protAct_nxt = ctrl_r[`PBG_CTRL_EN]
                    & ~(ctrl_r[`PBG_CTRL_PERMIT]
                    & pbg_pick(ctrl_r[`PBG_CTRL_SEL_HI:`PBG_CTRL_SEL_LO], assignVec));
      unique case (rl_r)
        TM_IDLE: begin
          if (nvAbove) begin
            rl_nxt    = TM_RUN;
            rlCnt_nxt = 16'h0000;
          end
        end
        TM_RUN: begin
          if (!nvAbove) rl_nxt = TM_IDLE;
          else if (rlCnt_r >= nvDly_r) rl_nxt = TM_DONE;
          else rlCnt_nxt = rlCnt_r + 16'h0001;
        end
        TM_DONE: begin
          if (!nvAbove) rl_nxt = TM_IDLE;
        end
      endcase
    end
    rel_nxt = (rl_nxt == TM_DONE);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      protActive  <= 1'b0;
      rl_r        <= TM_IDLE;
      rlCnt_r     <= 16'h0000;
      dirReleased <= 1'b0;
    end else begin
      protActive  <= protAct_nxt;
      rl_r        <= rl_nxt;
      rlCnt_r     <= rlCnt_nxt;
      dirReleased <= rel_nxt;
    end
  end

  assign dirBus = '{fwd: dirFwd, rev: dirRev, released: dirReleased};

  // stages
  genvar g;
  generate
    for (g = 0; g < NSTG; g++) begin : gStage
      assign sin[g] = '{pickup:  stagePickup[g],
                        blkA:    pbg_pick(cfg_r[g].selA, assignVec),
                        blkB:    pbg_pick(cfg_r[g].selB, assignVec),
                        tripBlk: pbg_pick(cfg_r[g].selTrip, assignVec)};
      pbg_stage uStage (
        .mclk       (mclk),
        .resetn     (resetn),
        .tick       (tick_r),
        .protActive (protActive),
        .freqOk     (filt_r[8]),
        .cfg        (cfg_r[g]),
        .delay      (dly_r[g]),
        .sin        (sin[g]),
        .dir        (dirBus),
        .sout       (sout[g])
      );
      assign stageActive[g] = sout[g].active;
      assign stageAlarm[g]  = sout[g].alarm;
      assign stageTrip[g]   = sout[g].trip;
      assign operVec[g]     = sout[g].operated;
    end
  endgenerate

  // general alarm and trip collect the stage outputs
  always_comb begin
    genAlarm_nxt = |stageAlarm;
    genTrip_nxt  = |stageTrip;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      genAlarm <= 1'b0;
      genTrip  <= 1'b0;
    end else begin
      genAlarm <= genAlarm_nxt;
      genTrip  <= genTrip_nxt;
    end
  end

  property p_globalOff;
    @(posedge mclk) disable iff (!resetn) tick_r && !ctrl_r[`PBG_CTRL_EN] |=> !protActive;
  endproperty
  a_globalOff: assert property (p_globalOff) else $error("protection active while disabled");

  property p_globalBlk;
    @(posedge mclk) disable iff (!resetn)
      tick_r && ctrl_r[`PBG_CTRL_PERMIT] && pbg_pick(ctrl_r[8:4], assignVec) |=> !protActive;
  endproperty
  a_globalBlk: assert property (p_globalBlk) else $error("protection active while blocked");

  property p_globalFree;
    @(posedge mclk) disable iff (!resetn)
      tick_r && ctrl_r[`PBG_CTRL_EN] && !(ctrl_r[`PBG_CTRL_PERMIT] && pbg_pick(ctrl_r[8:4], assignVec))
      |=> protActive;
  endproperty
  a_globalFree: assert property (p_globalFree) else $error("protection held off without block");

  property p_release;
    @(posedge mclk) disable iff (!resetn) $rose(dirReleased) |-> $past(nvAbove) && $past(rlCnt_r) >= $past(nvDly_r);
  endproperty
  a_release: assert property (p_release) else $error("direction released early");

  property p_tickSpacing;
    @(posedge mclk) disable iff (!resetn) tick_r |=> !tick_r [*8];
  endproperty
  a_tickSpacing: assert property (p_tickSpacing) else $error("processing tick too frequent");

  property p_genTrip;
    @(posedge mclk) disable iff (!resetn) (stageTrip == 4'h0) |=> !genTrip;
  endproperty
  a_genTrip: assert property (p_genTrip) else $error("general trip without stage trip");

endmodule : pbg_gate_top

`default_nettype wire

/* File: rtl/pbg_pkg.sv */
// types shared by the protection blocking gate top and its stage module
// assumes pbg_regs.svh is on the include path
`include "pbg_regs.svh"

package pbg_pkg;

  // direction a stage answers to
  typedef enum logic [1:0] {
    DIR_NONE = 2'h0,
    DIR_FWD  = 2'h1,
    DIR_REV  = 2'h2
  } pbg_dir_mode_t;

  // timer states, used by stage delay and neutral release delay
  typedef enum logic [2:0] {
    TM_IDLE = 3'b001,
    TM_RUN  = 3'b010,
    TM_DONE = 3'b100
  } pbg_tmr_state_t;

  // per-stage configuration, laid out as its register
  typedef struct packed {
    logic [4:0]    selTrip;
    logic [4:0]    selB;
    logic [4:0]    selA;
    pbg_dir_mode_t dirMode;
    logic          supervOnly;
    logic          usesRms;
    logic          extTripPermit;
    logic          tripPermBlock;
    logic          extBlockPermit;
    logic          enable;
  } pbg_stage_cfg_t;

  typedef struct packed {
    logic fwd;
    logic rev;
    logic released;
  } pbg_dir_t;

  typedef struct packed {
    logic pickup;
    logic blkA;
    logic blkB;
    logic tripBlk;
  } pbg_stage_in_t;

  typedef struct packed {
    logic active;
    logic alarm;
    logic operated;
    logic trip;
  } pbg_stage_out_t;

  // selector 0 means no assignment, n picks list entry n-1
  function automatic logic pbg_pick(input logic [4:0] sel, input logic [15:0] vec);
    logic [4:0] idx;
    idx = sel - 5'h01;
    return (sel == 5'h00) ? 1'b0 : vec[idx[3:0]];
  endfunction : pbg_pick

endpackage : pbg_pkg

/* File: rtl/pbg_regs.svh */
// register offsets, field positions, reset values and timing counts
// for the protection blocking gate; included by the package and the top
`ifndef PBG_REGS_SVH
`define PBG_REGS_SVH

// sizes
`define PBG_NSTG      4
`define PBG_PIN_W     8
`define PBG_ASSIGN_W  16
`define PBG_SEL_W     5
`define PBG_CFG_W     23
`define PBG_CNT_W     16

// byte offsets on the bus
`define PBG_OFS_CTRL   8'h00
`define PBG_OFS_STATUS 8'h04
`define PBG_OFS_NVMIN  8'h08
`define PBG_OFS_NVDLY  8'h0c
`define PBG_OFS_STG0   8'h10
`define PBG_OFS_STGEND 8'h30

// control register fields
`define PBG_CTRL_EN     0
`define PBG_CTRL_PERMIT 1
`define PBG_CTRL_SEL_LO 4
`define PBG_CTRL_SEL_HI 8

// reset values
`define PBG_CTRL_RST  9'h000
`define PBG_CFG_RST   23'h000000
`define PBG_CNT_RST   16'h0000

// timing: processing cycle derived from the clock period
`define PBG_MCLK_NS   50
`define PBG_PROC_NS   1000
`define PBG_PROC_CYC  (`PBG_PROC_NS / `PBG_MCLK_NS)

`endif

/* File: rtl/pbg_stage.sv */
// one protection stage: activity gate, direction check, delay timer, trip gate
// assumes tick is a one-cycle pulse per processing cycle from the top
`timescale 1ns/100ps
`default_nettype none

module pbg_stage
  import pbg_pkg::*;
(
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           resetn,
  // processing cycle and global state
  input  wire logic           tick,
  input  wire logic           protActive,
  input  wire logic           freqOk,
  // configuration
  input  wire pbg_stage_cfg_t cfg,
  input  wire logic [15:0]    delay,
  // live signals
  input  wire pbg_stage_in_t  sin,
  input  wire pbg_dir_t       dir,
  // results
  output var  pbg_stage_out_t sout
);

  pbg_tmr_state_t st_r, st_nxt;
  logic [15:0]    cnt_r, cnt_nxt;
  pbg_stage_out_t out_nxt;
  logic           dirOk, actv, pick;

  // gate terms and timer, stepped once per processing cycle
  always_comb begin
    case (cfg.dirMode)
      DIR_FWD: dirOk = dir.released & dir.fwd;
      DIR_REV: dirOk = dir.released & dir.rev;
      default: dirOk = 1'b1;
    endcase
    // rms elements ignore the frequency window
    actv = protActive & cfg.enable & ~(cfg.extBlockPermit & (sin.blkA | sin.blkB))
           & (cfg.usesRms | freqOk);
    pick = actv & sin.pickup & dirOk;
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    out_nxt = sout;
    if (tick) begin
      // delay only starts once direction is released, so delays add
      unique case (st_r)
        TM_IDLE: begin
          if (pick) begin
            st_nxt  = TM_RUN;
            cnt_nxt = 16'h0000;
          end
        end
        TM_RUN: begin
          if (!pick) st_nxt = TM_IDLE;
          else if (cnt_r >= delay) st_nxt = TM_DONE;
          else cnt_nxt = cnt_r + 16'h0001;
        end
        TM_DONE: begin
          if (!pick) st_nxt = TM_IDLE;
        end
      endcase
      out_nxt.active   = actv;
      out_nxt.alarm    = pick & ~cfg.supervOnly;
      out_nxt.operated = (st_nxt == TM_DONE);
      out_nxt.trip     = (st_nxt == TM_DONE) & ~cfg.supervOnly & ~cfg.tripPermBlock
                         & ~(cfg.extTripPermit & sin.tripBlk);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r  <= TM_IDLE;
      cnt_r <= 16'h0000;
      sout  <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      sout  <= out_nxt;
    end
  end

  property p_permBlock;
    @(posedge mclk) disable iff (!resetn) tick && cfg.tripPermBlock |=> !sout.trip;
  endproperty
  a_permBlock: assert property (p_permBlock) else $error("trip with permanent block");

  property p_extTrip;
    @(posedge mclk) disable iff (!resetn) tick && cfg.extTripPermit && sin.tripBlk |=> !sout.trip;
  endproperty
  a_extTrip: assert property (p_extTrip) else $error("trip while externally blocked");

  property p_superv;
    @(posedge mclk) disable iff (!resetn) tick && cfg.supervOnly |=> !sout.trip && !sout.alarm;
  endproperty
  a_superv: assert property (p_superv) else $error("supervision stage raised output");

  property p_freq;
    @(posedge mclk) disable iff (!resetn) tick && !cfg.usesRms && !freqOk |=> !sout.active;
  endproperty
  a_freq: assert property (p_freq) else $error("active outside frequency range");

  property p_rms;
    @(posedge mclk) disable iff (!resetn)
      tick && cfg.usesRms && protActive && cfg.enable && !(cfg.extBlockPermit && (sin.blkA || sin.blkB))
      |=> sout.active;
  endproperty
  a_rms: assert property (p_rms) else $error("rms stage not active");

  property p_extBlk;
    @(posedge mclk) disable iff (!resetn) tick && cfg.extBlockPermit && (sin.blkA || sin.blkB) |=> !sout.active;
  endproperty
  a_extBlk: assert property (p_extBlk) else $error("active while blocked");

  property p_disabled;
    @(posedge mclk) disable iff (!resetn) tick && (!cfg.enable || !protActive) |=> !sout.active && !sout.alarm;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled stage active");

  property p_dir;
    @(posedge mclk) disable iff (!resetn) tick && cfg.dirMode == DIR_FWD && !(dir.fwd && dir.released) |=> !sout.alarm;
  endproperty
  a_dir: assert property (p_dir) else $error("forward stage picked up without forward");

  property p_delay;
    @(posedge mclk) disable iff (!resetn) $rose(sout.operated) |-> $past(cnt_r) >= $past(delay);
  endproperty
  a_delay: assert property (p_delay) else $error("operated before delay elapsed");

endmodule : pbg_stage

`default_nettype wire

/* File: verification/pbg_far_side.sv */
// far side of the gate: relay contacts on the assignable blocking pins
// and the frequency supervision contact; assumes one mclk domain
`timescale 1ns/100ps
`default_nettype none

module pbg_far_side (
  // clock
  input  wire logic       mclk,
  // commands from the bench
  input  wire logic [7:0] blockCmd,
  input  wire logic       freqCmd,
  // pins toward the gate
  output var  logic [7:0] assignPin,
  output var  logic       freqInRangePin
);
  // contacts follow the command one edge late, like a real relay output
  always_ff @(posedge mclk) begin
    assignPin      <= blockCmd;
    freqInRangePin <= freqCmd;
  end
endmodule : pbg_far_side

`default_nettype wire

/* File: verification/protection_blocking_gate_test.sv */
// bench for the protection blocking gate: wishbone tasks and gating cases
// assumes pbg_pkg, pbg_regs.svh and pbg_far_side are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "pbg_regs.svh"

module protection_blocking_gate_test;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [7:0]  blockCmd = 8'h00;
  logic        freqCmd = 1'b1;
  logic [15:0] nv = 16'h0;
  logic        dirFwd = 1'b0;
  logic        dirRev = 1'b0;
  logic [3:0]  pickup = 4'h0;
  wire  [31:0] wbDat;
  wire         wbAck;
  wire  [7:0]  assignPin;
  wire         freqPin;
  wire         protActive;
  wire         dirReleased;
  wire  [3:0]  stageActive;
  wire  [3:0]  stageAlarm;
  wire  [3:0]  stageTrip;
  wire         genAlarm;
  wire         genTrip;
  int          nMismatch = 0;
  int          comparisons = 0;

  always #25 mclk = ~mclk;

  pbg_far_side u_pbg_far_side (.mclk(mclk), .blockCmd(blockCmd), .freqCmd(freqCmd),
    .assignPin(assignPin), .freqInRangePin(freqPin));

  pbg_gate_top u_pbg_gate_top (.mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wbDat),
    .wb_ack_o(wbAck), .assignPin(assignPin), .freqInRangePin(freqPin), .neutralVoltage(nv),
    .dirFwd(dirFwd), .dirRev(dirRev), .stagePickup(pickup), .protActive(protActive),
    .dirReleased(dirReleased), .stageActive(stageActive), .stageAlarm(stageAlarm),
    .stageTrip(stageTrip), .genAlarm(genAlarm), .genTrip(genTrip));

  task print_verdict;
    $display("compares %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // port level compare
  task chk_port(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_port

  // one classic cycle; request held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    for (i = 0; i < 20 && wbAck !== 1'b1; i++) @(posedge mclk);
    if (i == 20) begin
      nMismatch++;
      print_verdict();
    end
    rdat = wbDat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  // register read compare
  task chk_reg(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk_port(rdat, exp);
  endtask : chk_reg

  // the processing cycle is fixed at 20 mclk, so whole ticks are waited
  task ticks(input int n);
    repeat (n * `PBG_PROC_CYC + 5) @(posedge mclk);
  endtask : ticks

  task done(input string name);
    $display("test %s finished", name);
  endtask : done

  // stage 0 setup, then compare {active, trip}
  task gate(input logic [22:0] cfg, input logic [7:0] pins, input logic [3:0] pick,
            input logic f, input logic [1:0] exp);
    wr(`PBG_OFS_STG0, {9'h0, cfg});
    blockCmd <= pins;
    pickup <= pick;
    freqCmd <= f;
    ticks(5);
    chk_port({30'h0, stageActive[0], stageTrip[0]}, {30'h0, exp});
  endtask : gate

  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    chk_reg(`PBG_OFS_STATUS, 32'h0);
    chk_reg(`PBG_OFS_CTRL, 32'h0);
    wr(8'h40, 32'hffffffff);
    chk_reg(8'h40, 32'h0);
    done("reset");
    wr(`PBG_OFS_STG0 + 8'h04, 32'h2);
    wr(`PBG_OFS_STG0 + 8'h08, 32'h1);
    wr(`PBG_OFS_STG0, 32'h1);
    pickup <= 4'h1;
    ticks(5);
    chk_port({28'h0, stageActive}, 32'h0);
    chk_port({28'h0, stageTrip}, 32'h0);
    wr(`PBG_OFS_CTRL, 32'h1);
    ticks(2);
    chk_port({31'h0, stageActive[0]}, 32'h1);
    chk_port({31'h0, stageTrip[0]}, 32'h0);
    ticks(3);
    chk_port({30'h0, stageTrip[0], genTrip}, 32'h3);
    done("global");
    wr(`PBG_OFS_CTRL, 32'h13);
    blockCmd <= 8'h01;
    ticks(2);
    chk_port({30'h0, protActive, stageActive[0]}, 32'h0);
    blockCmd <= 8'h00;
    ticks(2);
    chk_port({31'h0, protActive}, 32'h1);
    wr(`PBG_OFS_CTRL, 32'h11);
    blockCmd <= 8'h01;
    ticks(2);
    chk_port({31'h0, protActive}, 32'h1);
    wr(`PBG_OFS_CTRL, 32'h1);
    done("global block");
    gate(23'h000005, 8'h00, 4'h1, 1'b1, 2'b10);
    chk_reg(`PBG_OFS_STATUS, 32'h00101131);
    gate(23'h014203, 8'h02, 4'h1, 1'b1, 2'b00);
    gate(23'h014203, 8'h00, 4'h1, 1'b1, 2'b11);
    gate(23'h014203, 8'h00, 4'h3, 1'b1, 2'b00);
    gate(23'h014201, 8'h02, 4'h3, 1'b1, 2'b11);
    gate(23'h100009, 8'h08, 4'h1, 1'b1, 2'b10);
    gate(23'h100001, 8'h08, 4'h1, 1'b1, 2'b11);
    gate(23'h000001, 8'h00, 4'h1, 1'b0, 2'b00);
    gate(23'h000011, 8'h00, 4'h1, 1'b0, 2'b11);
    gate(23'h000021, 8'h00, 4'h1, 1'b1, 2'b10);
    chk_port({30'h0, genAlarm, genTrip}, 32'h0);
    gate(23'h000000, 8'h00, 4'h1, 1'b1, 2'b00);
    done("stage blocks");
    wr(`PBG_OFS_NVMIN, 32'h64);
    wr(`PBG_OFS_NVDLY, 32'h3);
    dirFwd <= 1'b1;
    nv <= 16'h0064;
    gate(23'h000041, 8'h00, 4'h1, 1'b1, 2'b10);
    chk_port({31'h0, dirReleased}, 32'h0);
    nv <= 16'h0065;
    ticks(5);
    chk_port({30'h0, dirReleased, stageTrip[0]}, 32'h2);
    ticks(4);
    chk_port({31'h0, stageTrip[0]}, 32'h1);
    gate(23'h000081, 8'h00, 4'h1, 1'b1, 2'b10);
    dirFwd <= 1'b0;
    dirRev <= 1'b1;
    ticks(5);
    chk_port({31'h0, stageTrip[0]}, 32'h1);
    nv <= 16'h0;
    ticks(2);
    chk_port({31'h0, dirReleased}, 32'h0);
    done("direction");
    print_verdict();
  end
endmodule : protection_blocking_gate_test

`default_nettype wire
